// ### design/pmt_core.sv
// Program counter, entry vectors, interrupt requests and table reads.
// Assumes a core that obeys core_hold and owns the return stack.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// RULE_01 - Counter addresses store for instruction fetch
// RULE_02 - Reset loads counter with reset entry
// RULE_03 - Enabled external edge vectors unless stack full
// RULE_04 - External edge: rising, falling or both
// RULE_05 - Enabled timer overflow vectors unless stack full
// RULE_06 - Enabled conversion done vectors unless stack full
// RULE_07 - Tables readable anywhere in the store; reads here reach only the counter's current page or the last page
// RULE_08 - Table pointer gives address bits seven..zero
// RULE_09 - Current page read takes counter bits 9,8
// RULE_10 - Last page read forces bits 9,8 high
// RULE_11 - Low byte written to operand data register
// RULE_12 - High part loaded into table high register
// RULE_13 - Unused table high bits read zero
// RULE_14 - Table high register ignores software writes
// RULE_15 - Table read takes two instruction cycles
// RULE_16 - Software masks interrupts around shared reads
// RULE_17 - Full stack keeps request pending until freed
// RULE_18 - Fixed distinct entry addresses near bottom
module pmt_core (
	input  wire logic                       mclk,
	input  wire logic                       rst_b,
	input  wire logic [7:0]                 reg_addr,
	input  wire logic [7:0]                 reg_wdata,
	input  wire logic                       reg_wr,
	input  wire logic                       reg_rd,
	output logic      [7:0]                 reg_rdata,
	input  wire logic                       load_en,
	input  wire logic [pmt_pkg::PMT_AW-1:0] load_addr,
	input  wire logic [pmt_pkg::PMT_DW-1:0] load_data,
	input  wire logic                       branch_req,
	input  wire logic [pmt_pkg::PMT_AW-1:0] branch_addr,
	input  wire logic                       tbl_req,
	input  wire logic                       tbl_last,
	input  wire logic [7:0]                 tbl_dest,
	input  wire logic                       stack_full,
	input  wire pmt_pkg::pmt_evt_t          evt,
	output logic                            instr_cyc,
	output logic                            core_hold,
	output logic      [pmt_pkg::PMT_AW-1:0] pc,
	output logic      [pmt_pkg::PMT_DW-1:0] instr_word,
	output logic                            int_ack,
	output logic      [pmt_pkg::PMT_AW-1:0] push_addr,
	output pmt_pkg::pmt_tbl_wr_t            tbl_wr,
	output logic                            irq
);

	localparam int AW = pmt_pkg::PMT_AW;
	localparam int NI = pmt_pkg::PMT_NIRQ;

	logic [1:0]                 phase_q, phase_d;
	logic [AW-1:0]              pc_q, pc_d;
	logic [AW-1:0]              tbl_addr_q, tbl_addr_d;
	logic [7:0]                 tbl_ptr_q, tbl_ptr_d;
	logic [7:0]                 tbl_high_q, tbl_high_d;
	logic [7:0]                 tbl_dest_q, tbl_dest_d;
	pmt_pkg::pmt_tstate_t       ts_q, ts_d;
	pmt_pkg::pmt_tbl_wr_t       tbl_wr_q, tbl_wr_d;
	pmt_pkg::pmt_edge_t         edge_q, edge_d;
	logic [NI-1:0]              en_q, en_d;
	logic [NI-1:0]              req_q, req_d;
	logic [NI-1:0]              set_v, clr_v, ack_v;
	logic                       ext_prev_q;
	logic                       ack_q, ack_d;
	logic [AW-1:0]              push_q, push_d;
	logic [7:0]                 rdata_q, rdata_d;
	logic [AW-1:0]              rom_addr;
	logic [pmt_pkg::PMT_DW-1:0] rom_data;
	logic                       tbl_start, ack_now, ext_rise, ext_fall;
	logic [AW-1:0]              vec_sel;

	// Instruction cycle: four core clocks, one enable pulse at the last
	always_comb begin
		phase_d = phase_q + 2'h1;
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			phase_q <= 2'h0;
		end else begin
			phase_q <= phase_d;
		end
	end

	assign instr_cyc = (phase_q == pmt_pkg::PMT_T_LAST);

	// While a table read runs the store is borrowed from instruction fetch
	assign rom_addr = (ts_q == pmt_pkg::PMT_TS_IDLE) ? pc_q : tbl_addr_q; // RULE_01 RULE_07

	pmt_rom u_rom (
		.mclk      (mclk),
		.load_en   (load_en),
		.load_addr (load_addr),
		.load_data (load_data),
		.rd_addr   (rom_addr),
		.rd_data   (rom_data)
	);

	assign instr_word = rom_data;

	// External edge detection per selected polarity
	assign ext_rise = evt.ext_pin & ~ext_prev_q;
	assign ext_fall = ~evt.ext_pin & ext_prev_q;

	always_comb begin
		set_v = '0;
		case (edge_q) // RULE_04
			pmt_pkg::PMT_EDGE_RISE: set_v[pmt_pkg::PMT_IRQ_EXT] = ext_rise;
			pmt_pkg::PMT_EDGE_FALL: set_v[pmt_pkg::PMT_IRQ_EXT] = ext_fall;
			pmt_pkg::PMT_EDGE_BOTH: set_v[pmt_pkg::PMT_IRQ_EXT] =
				ext_rise | ext_fall;
			default:                set_v[pmt_pkg::PMT_IRQ_EXT] = 1'b0;
		endcase
		set_v[pmt_pkg::PMT_IRQ_TMR] = evt.tmr_ovf;
		set_v[pmt_pkg::PMT_IRQ_ADC] = evt.adc_done;
	end

	// Acknowledge only at an instruction boundary that does not already
	// redirect the counter; a full stack leaves the request pending
	assign tbl_start = instr_cyc && (ts_q == pmt_pkg::PMT_TS_IDLE) && tbl_req;
	assign ack_now   = instr_cyc && (ts_q == pmt_pkg::PMT_TS_IDLE) &&
		!tbl_req && !branch_req && !stack_full && irq; // RULE_17

	always_comb begin
		ack_v   = '0;
		vec_sel = pmt_pkg::PMT_VEC_EXT;
		if (ack_now) begin
			if (req_q[pmt_pkg::PMT_IRQ_EXT] && en_q[pmt_pkg::PMT_IRQ_EXT]) begin
				ack_v[pmt_pkg::PMT_IRQ_EXT] = 1'b1;
				vec_sel = pmt_pkg::PMT_VEC_EXT; // RULE_03 RULE_18
			end else if (req_q[pmt_pkg::PMT_IRQ_TMR] &&
				en_q[pmt_pkg::PMT_IRQ_TMR]) begin
				ack_v[pmt_pkg::PMT_IRQ_TMR] = 1'b1;
				vec_sel = pmt_pkg::PMT_VEC_TMR; // RULE_05 RULE_18
			end else begin
				ack_v[pmt_pkg::PMT_IRQ_ADC] = 1'b1;
				vec_sel = pmt_pkg::PMT_VEC_ADC; // RULE_06 RULE_18
			end
		end
	end

	assign clr_v = (reg_wr && reg_addr == pmt_pkg::PMT_REG_INT_CLR) ?
		reg_wdata[NI-1:0] : '0;

	// Request flags: a new event wins over a clear in the same cycle
	always_comb begin
		req_d  = (req_q & ~clr_v & ~ack_v) | set_v;
		ack_d  = ack_now;
		push_d = ack_now ? pc_q : push_q;
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			req_q      <= '0;
			ext_prev_q <= 1'b0;
			ack_q      <= 1'b0;
			push_q     <= '0;
		end else begin
			req_q      <= req_d;
			ext_prev_q <= evt.ext_pin;
			ack_q      <= ack_d;
			push_q     <= push_d;
		end
	end

	assign irq       = |(req_q & en_q);
	assign int_ack   = ack_q;
	assign push_addr = push_q;

	// Program counter
	always_comb begin
		pc_d = pc_q;
		if (instr_cyc && ts_q == pmt_pkg::PMT_TS_IDLE) begin
			if (tbl_start) begin
				pc_d = pc_q;
			end else if (ack_now) begin
				pc_d = vec_sel;
			end else if (branch_req) begin
				pc_d = branch_addr;
			end else begin
				pc_d = pc_q + 10'h001; // RULE_01
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			pc_q <= pmt_pkg::PMT_VEC_RST; // RULE_02
		end else begin
			pc_q <= pc_d;
		end
	end

	assign pc = pc_q;

	// Table read sequencer: fetch cycle then finishing cycle
	always_comb begin
		ts_d       = ts_q;
		tbl_addr_d = tbl_addr_q;
		tbl_dest_d = tbl_dest_q;
		tbl_high_d = tbl_high_q;
		tbl_wr_d   = '0;
		case (ts_q)
			pmt_pkg::PMT_TS_IDLE: begin
				if (tbl_start) begin
					ts_d       = pmt_pkg::PMT_TS_FETCH;
					tbl_dest_d = tbl_dest;
					tbl_addr_d[7:0] = tbl_ptr_q; // RULE_08
					tbl_addr_d[9:8] = tbl_last ? pmt_pkg::PMT_LAST_PAGE :
						pc_q[9:8]; // RULE_09 RULE_10
				end
			end
			pmt_pkg::PMT_TS_FETCH: begin
				if (instr_cyc) begin
					ts_d          = pmt_pkg::PMT_TS_DONE;
					tbl_wr_d.en   = 1'b1;
					tbl_wr_d.addr = tbl_dest_q;
					tbl_wr_d.data = rom_data[7:0]; // RULE_11
					tbl_high_d    = {2'h0, rom_data[13:8]}; // RULE_12 RULE_13
				end
			end
			pmt_pkg::PMT_TS_DONE: begin
				if (instr_cyc) begin
					ts_d = pmt_pkg::PMT_TS_IDLE; // RULE_15
				end
			end
			default: ts_d = pmt_pkg::PMT_TS_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			ts_q       <= pmt_pkg::PMT_TS_IDLE;
			tbl_addr_q <= '0;
			tbl_dest_q <= 8'h00;
			tbl_high_q <= 8'h00;
			tbl_wr_q   <= '0;
		end else begin
			ts_q       <= ts_d;
			tbl_addr_q <= tbl_addr_d;
			tbl_dest_q <= tbl_dest_d;
			tbl_high_q <= tbl_high_d;
			tbl_wr_q   <= tbl_wr_d;
		end
	end

	assign core_hold = (ts_q != pmt_pkg::PMT_TS_IDLE); // RULE_15
	assign tbl_wr    = tbl_wr_q;

	// Register port; the table high register has no write path
	always_comb begin
		tbl_ptr_d = tbl_ptr_q;
		edge_d    = edge_q;
		en_d      = en_q;
		if (reg_wr) begin
			case (reg_addr) // RULE_14
				pmt_pkg::PMT_REG_TBL_PTR: tbl_ptr_d = reg_wdata;
				pmt_pkg::PMT_REG_CTRL:
					edge_d = pmt_pkg::pmt_edge_t'(reg_wdata[1:0]);
				pmt_pkg::PMT_REG_INT_EN:  en_d = reg_wdata[NI-1:0];
				default: ;
			endcase
		end
		rdata_d = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				pmt_pkg::PMT_REG_TBL_PTR:  rdata_d = tbl_ptr_q;
				pmt_pkg::PMT_REG_TBL_HIGH: rdata_d = tbl_high_q;
				pmt_pkg::PMT_REG_CTRL:     rdata_d = {6'h00, edge_q};
				pmt_pkg::PMT_REG_INT_EN:   rdata_d = {5'h00, en_q};
				pmt_pkg::PMT_REG_INT_STAT: rdata_d = {5'h00, req_q};
				default:                   rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			tbl_ptr_q <= pmt_pkg::PMT_TBL_PTR_RST;
			edge_q    <= pmt_pkg::pmt_edge_t'(pmt_pkg::PMT_EDGE_RST);
			en_q      <= pmt_pkg::PMT_INT_EN_RST;
			rdata_q   <= 8'h00;
		end else begin
			tbl_ptr_q <= tbl_ptr_d;
			edge_q    <= edge_d;
			en_q      <= en_d;
			rdata_q   <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;

	// Checks
	logic started_q;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			started_q <= 1'b0;
		end else if (instr_cyc) begin
			started_q <= 1'b1;
		end
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_b);

	pc_reset_a: assert property (!started_q |-> pc_q == 10'h000) // RULE_02
		else $error("counter left the reset entry before first cycle");
	ext_vector_a: assert property (ack_now && ack_v[0] |=> // RULE_03
		pc_q == pmt_pkg::PMT_VEC_EXT && int_ack)
		else $error("external request did not vector");
	tmr_vector_a: assert property (ack_now && ack_v[1] |=> // RULE_05
		pc_q == pmt_pkg::PMT_VEC_TMR)
		else $error("timer request did not vector");
	adc_vector_a: assert property (ack_now && ack_v[2] |=> // RULE_06
		pc_q == pmt_pkg::PMT_VEC_ADC)
		else $error("conversion request did not vector");
	full_stack_a: assert property (irq && stack_full && clr_v == '0 // RULE_17
		|=> !int_ack && irq)
		else $error("request lost or taken with full stack");
	edge_rise_a: assert property (edge_q == pmt_pkg::PMT_EDGE_RISE && // RULE_04
		ext_rise |=> req_q[0])
		else $error("rising edge not recorded");
	cur_page_a: assert property (tbl_start && !tbl_last |=> // RULE_09
		tbl_addr_q == {$past(pc_q[9:8]), $past(tbl_ptr_q)})
		else $error("current page table address wrong");
	last_page_a: assert property (tbl_start && tbl_last |=> // RULE_10
		tbl_addr_q == {2'h3, $past(tbl_ptr_q)})
		else $error("last page table address wrong");
	tbl_two_cyc_a: assert property (tbl_start |=> // RULE_15
		core_hold [*8] ##1 !core_hold)
		else $error("table read not two instruction cycles");
	high_ro_a: assert property (reg_wr && !tbl_wr_d.en |=> // RULE_14
		$stable(tbl_high_q))
		else $error("table high changed without a table read");
	// Compared against the stored word itself, not the read path
	high_zero_a: assert property (tbl_wr_q.en |-> // RULE_13
		tbl_high_q == {2'h0, u_rom.mem[tbl_addr_q][13:8]} &&
		tbl_wr_q.data == u_rom.mem[tbl_addr_q][7:0])
		else $error("table data transfer wrong");

	tbl_last_c: cover property (tbl_start && tbl_last ##9 tbl_wr_q.en == 1'b0);
	ext_ack_c:  cover property (ack_now && ack_v[0]);
	full_wait_c: cover property (irq && stack_full ##1 ack_now);

endmodule : pmt_core

`default_nettype wire

// ### design/pmt_pkg.sv
// Constants, types and register map of the program store and table reader.
// Assumes one core clock and a core that sequences instructions on the
// instruction-cycle enable made inside the block.
package pmt_pkg;

	localparam int PMT_AW       = 10;
	localparam int PMT_DW       = 14;
	localparam int PMT_DEPTH    = 1024;
	localparam int PMT_T_PHASES = 4;

	localparam logic [1:0] PMT_T_LAST = 2'h3;

	// Entry points, near the bottom of the store, and the last table page
	localparam logic [PMT_AW-1:0] PMT_VEC_RST = 10'h000;
	localparam logic [PMT_AW-1:0] PMT_VEC_EXT = 10'h004;
	localparam logic [PMT_AW-1:0] PMT_VEC_TMR = 10'h008;
	localparam logic [PMT_AW-1:0] PMT_VEC_ADC = 10'h00c;
	localparam logic [1:0]        PMT_LAST_PAGE = 2'h3;

	// Register offsets on the plain register port
	localparam logic [7:0] PMT_REG_INT_EN   = 8'h0b;
	localparam logic [7:0] PMT_REG_TBL_PTR  = 8'h07;
	localparam logic [7:0] PMT_REG_TBL_HIGH = 8'h08;
	localparam logic [7:0] PMT_REG_INT_STAT = 8'h0e;
	localparam logic [7:0] PMT_REG_INT_CLR  = 8'h0f;
	localparam logic [7:0] PMT_REG_CTRL     = 8'h1b;

	// Interrupt bit positions, highest priority first
	localparam int PMT_IRQ_EXT = 0;
	localparam int PMT_IRQ_TMR = 1;
	localparam int PMT_IRQ_ADC = 2;
	localparam int PMT_NIRQ    = 3;

	// Reset values
	localparam logic [7:0]          PMT_TBL_PTR_RST = 8'h00;
	localparam logic [1:0]          PMT_EDGE_RST    = 2'h2;
	localparam logic [PMT_NIRQ-1:0] PMT_INT_EN_RST  = 3'h0;

	// External edge selection, bits [1:0] of system_control_second
	typedef enum logic [1:0] {
		PMT_EDGE_OFF  = 2'h0,
		PMT_EDGE_RISE = 2'h1,
		PMT_EDGE_FALL = 2'h2,
		PMT_EDGE_BOTH = 2'h3
	} pmt_edge_t;

	// Table sequencer, Gray along idle -> fetch -> finish
	typedef enum logic [1:0] {
		PMT_TS_IDLE  = 2'b00,
		PMT_TS_FETCH = 2'b01,
		PMT_TS_DONE  = 2'b11
	} pmt_tstate_t;

	typedef struct packed {
		logic ext_pin;
		logic tmr_ovf;
		logic adc_done;
	} pmt_evt_t;

	typedef struct packed {
		logic       en;
		logic [7:0] addr;
		logic [7:0] data;
	} pmt_tbl_wr_t;

endpackage : pmt_pkg

// ### design/pmt_rom.sv
// Program store: flip-flop array with a load port and a registered read.
// Assumes the load port is only used while the core is held in reset.
`timescale 1ns/1ps
`default_nettype none

module pmt_rom (
	input  wire logic                       mclk,
	input  wire logic                       load_en,
	input  wire logic [pmt_pkg::PMT_AW-1:0] load_addr,
	input  wire logic [pmt_pkg::PMT_DW-1:0] load_data,
	input  wire logic [pmt_pkg::PMT_AW-1:0] rd_addr,
	output logic      [pmt_pkg::PMT_DW-1:0] rd_data
);

	logic [pmt_pkg::PMT_DW-1:0] mem [pmt_pkg::PMT_DEPTH];

	// No reset on the array: it models one-time programmed contents
	always_ff @(posedge mclk) begin
		if (load_en) begin
			mem[load_addr] <= load_data;
		end
		rd_data <= mem[rd_addr];
	end

endmodule : pmt_rom

`default_nettype wire

// ### bench/pmt_testbench.sv
// Self-checking bench for the program store, entry vectors and table reads.
// Assumes pmt_core holds the store inside and that no core sits beside it:
// the bench plays the core, the register master and the event sources.
`timescale 1ns/1ps
`default_nettype none

module testbench;
	logic                       mclk;
	logic                       rst_b;
	logic [7:0]                 reg_addr;
	logic [7:0]                 reg_wdata;
	logic                       reg_wr;
	logic                       reg_rd;
	logic [7:0]                 reg_rdata;
	logic                       load_en;
	logic [pmt_pkg::PMT_AW-1:0] load_addr;
	logic [pmt_pkg::PMT_DW-1:0] load_data;
	logic                       branch_req;
	logic [pmt_pkg::PMT_AW-1:0] branch_addr;
	logic                       tbl_req;
	logic                       tbl_last;
	logic [7:0]                 tbl_dest;
	logic                       stack_full;
	pmt_pkg::pmt_evt_t          evt;
	logic                       instr_cyc;
	logic                       core_hold;
	logic [pmt_pkg::PMT_AW-1:0] pc;
	logic [pmt_pkg::PMT_DW-1:0] instr_word;
	logic                       int_ack;
	logic [pmt_pkg::PMT_AW-1:0] push_addr;
	pmt_pkg::pmt_tbl_wr_t       tbl_wr;
	logic                       irq;
	logic [7:0]                 rd;
	logic [9:0]                 used [6] = '{10'h000, 10'h0ff, 10'h2f1,
		10'h2ff, 10'h300, 10'h3ff};
	int                         err_count = 0;
	int                         tests_run = 0;

	pmt_core dut_u (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .load_en(load_en), .load_addr(load_addr),
		.load_data(load_data), .branch_req(branch_req),
		.branch_addr(branch_addr), .tbl_req(tbl_req), .tbl_last(tbl_last),
		.tbl_dest(tbl_dest), .stack_full(stack_full), .evt(evt),
		.instr_cyc(instr_cyc), .core_hold(core_hold), .pc(pc),
		.instr_word(instr_word), .int_ack(int_ack), .push_addr(push_addr),
		.tbl_wr(tbl_wr), .irq(irq));

	always #2.5 mclk = ~mclk;

	// Upper bits vary with the address so a page slip shows in the data
	function automatic logic [13:0] word_of(input logic [9:0] a);
		return 14'h2a5c ^ {a[3:0], a};
	endfunction : word_of

	task automatic finish_test;
		$display("Comparisons %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : finish_test

	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_val

	task automatic chk_bit(input logic got, input logic exp);
		chk_val({15'h0000, got}, {15'h0000, exp});
	endtask : chk_bit

	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : reg_write

	task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : reg_read

	// Leaves the caller on the edge that opens an instruction-boundary cycle
	task automatic align;
		int n;
		n = 0;
		@(posedge mclk);
		#1;
		while (instr_cyc !== 1'b1 && n < 8) begin
			@(posedge mclk);
			#1;
			n++;
		end
		chk_bit(instr_cyc, 1'b1);
		repeat (4) @(posedge mclk);
	endtask : align

	task automatic jump(input logic [9:0] a);
		align;
		branch_req  <= 1'b1;
		branch_addr <= a;
		@(posedge mclk);
		branch_req <= 1'b0;
		@(posedge mclk);
		#1 chk_val(16'(pc), 16'(a));
		@(posedge mclk);
		#1 chk_val(16'(instr_word), 16'(word_of(a)));
	endtask : jump

	task automatic tbl_read(input logic last, input logic [7:0] ptr,
		input logic [9:0] ea);
		logic [9:0] p;
		int         n;
		reg_write(pmt_pkg::PMT_REG_TBL_PTR, ptr);
		align;
		tbl_req  <= 1'b1;
		tbl_last <= last;
		tbl_dest <= ptr ^ 8'h5a;
		@(posedge mclk);
		tbl_req <= 1'b0;
		#1 p = pc;
		n = 0;
		while (tbl_wr.en !== 1'b1 && n < 10) begin
			@(posedge mclk);
			#1 n++;
		end
		chk_val(16'(n), 16'(pmt_pkg::PMT_T_PHASES));
		chk_bit(core_hold, 1'b1);
		chk_val(16'(pc), 16'(p));
		chk_val(16'(tbl_wr.addr), 16'(ptr ^ 8'h5a));
		chk_val(16'(tbl_wr.data), 16'(word_of(ea)) & 16'h00ff);
		n = 0;
		while (core_hold !== 1'b0 && n < 10) begin
			@(posedge mclk);
			#1 n++;
		end
		chk_bit(core_hold, 1'b0);
		reg_read(pmt_pkg::PMT_REG_TBL_HIGH, rd);
		chk_val(16'(rd), 16'(word_of(ea)) >> 8);
		reg_write(pmt_pkg::PMT_REG_TBL_HIGH, 8'hff);
		reg_read(pmt_pkg::PMT_REG_TBL_HIGH, rd);
		chk_val(16'(rd), 16'(word_of(ea)) >> 8);
	endtask : tbl_read

	task automatic wait_ack(input logic [9:0] vec);
		logic [9:0] prev;
		int         n;
		n = 0;
		// Let the previous acknowledge pulse pass before watching again
		#1;
		while (int_ack === 1'b1) begin
			@(posedge mclk);
			#1;
		end
		prev = pc;
		while (int_ack !== 1'b1 && n < 12) begin
			prev = pc;
			@(posedge mclk);
			#1 n++;
		end
		chk_bit(int_ack, 1'b1);
		chk_val(16'(pc), 16'(vec));
		chk_val(16'(push_addr), 16'(prev));
	endtask : wait_ack

	initial begin
		mclk = 1'b0;
		rst_b = 1'b0;
		{reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
		{load_en, load_addr, load_data} = '0;
		{branch_req, branch_addr, tbl_req, tbl_last, tbl_dest} = '0;
		stack_full = 1'b0;
		evt = '0;
		// The store is not reset, so it is filled while the core is held
		for (int i = 0; i < 10; i++) begin
			@(posedge mclk);
			load_en   <= (i < 6);
			load_addr <= used[i % 6];
			load_data <= word_of(used[i % 6]);
		end
		@(posedge mclk);
		rst_b <= 1'b1;
		@(posedge mclk);
		#1 chk_val(16'(pc), 16'(pmt_pkg::PMT_VEC_RST));
		chk_val(16'(instr_word), 16'(word_of(10'h000)));
		reg_read(pmt_pkg::PMT_REG_TBL_PTR, rd);
		chk_val(16'(rd), 16'h0000);
		reg_read(pmt_pkg::PMT_REG_CTRL, rd);
		chk_val(16'(rd), 16'h0002);
		reg_read(pmt_pkg::PMT_REG_INT_STAT, rd);
		chk_val(16'(rd), 16'h0000);
		// Table reads below run with every interrupt masked
		reg_read(pmt_pkg::PMT_REG_INT_EN, rd);
		chk_val(16'(rd), 16'h0000);
		reg_read(8'h30, rd);
		chk_val(16'(rd), 16'h0000);
		tbl_read(1'b0, 8'hff, 10'h0ff);
		jump(10'h2f1);
		tbl_read(1'b0, 8'hff, 10'h2ff);
		tbl_read(1'b1, 8'h00, 10'h300);
		tbl_read(1'b1, 8'hff, 10'h3ff);
		// All three requests at once behind a full stack
		reg_write(pmt_pkg::PMT_REG_CTRL, 8'h03);
		reg_write(pmt_pkg::PMT_REG_INT_EN, 8'h07);
		@(posedge mclk);
		stack_full <= 1'b1;
		evt        <= '{ext_pin: 1'b1, tmr_ovf: 1'b1, adc_done: 1'b1};
		@(posedge mclk);
		evt.tmr_ovf  <= 1'b0;
		evt.adc_done <= 1'b0;
		repeat (12) begin
			@(posedge mclk);
			#1 chk_bit(int_ack, 1'b0);
		end
		reg_read(pmt_pkg::PMT_REG_INT_STAT, rd);
		chk_val(16'(rd), 16'h0007);
		chk_bit(irq, 1'b1);
		@(posedge mclk);
		stack_full <= 1'b0;
		wait_ack(pmt_pkg::PMT_VEC_EXT);
		wait_ack(pmt_pkg::PMT_VEC_TMR);
		wait_ack(pmt_pkg::PMT_VEC_ADC);
		chk_bit(irq, 1'b0);
		reg_write(pmt_pkg::PMT_REG_INT_EN, 8'h00);
		for (int m = 0; m < 4; m++) begin
			reg_write(pmt_pkg::PMT_REG_CTRL, 8'(m));
			for (int j = 0; j < 2; j++) begin
				reg_write(pmt_pkg::PMT_REG_INT_CLR, 8'h07);
				@(posedge mclk);
				evt.ext_pin <= ~evt.ext_pin;
				repeat (3) @(posedge mclk);
				reg_read(pmt_pkg::PMT_REG_INT_STAT, rd);
				chk_bit(rd[0], m == 3 || m == (evt.ext_pin ? 1 : 2));
			end
		end
		chk_bit(irq, 1'b0);
		// Full stack keeps the acknowledge from doing the clear's work
		@(posedge mclk);
		stack_full <= 1'b1;
		reg_write(pmt_pkg::PMT_REG_INT_EN, 8'h01);
		#1 chk_bit(irq, 1'b1);
		reg_write(pmt_pkg::PMT_REG_INT_STAT, 8'h07);
		reg_read(pmt_pkg::PMT_REG_INT_STAT, rd);
		chk_val(16'(rd), 16'h0001);
		reg_write(pmt_pkg::PMT_REG_INT_CLR, 8'h01);
		#1 chk_bit(irq, 1'b0);
		reg_read(pmt_pkg::PMT_REG_INT_STAT, rd);
		chk_val(16'(rd), 16'h0000);
		finish_test;
	end

	// The whole run needs well under a thousand cycles
	initial begin
		#100000;
		err_count++;
		finish_test;
	end
endmodule : testbench

`default_nettype wire
